// >>> core/ntpseq_pkg.sv
// Package for the two-plane NAND host sequencer: commands, timing, states.
// Assumes a 125 MHz clock and an 8-bit multiplexed flash port.
package ntpseq_pkg;
  localparam int unsigned CLK_MHZ         = 125;
  localparam logic [7:0]  CMD_PAGE_PROG   = 8'h10;
  localparam logic [7:0]  CMD_DUMMY_PROG  = 8'h11;
  localparam logic [7:0]  CMD_CACHE_PROG  = 8'h15;
  localparam logic [7:0]  CMD_PROG_SETUP  = 8'h80;
  localparam logic [7:0]  CMD_NEXT_PLANE  = 8'h81;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0]  CMD_ERASE_CONF  = 8'hd0;
  localparam logic [7:0]  CMD_STATUS      = 8'h70;
  localparam logic [7:0]  CMD_RESET       = 8'hff;
  localparam int unsigned ROW_CYCLES      = 3;
  localparam int unsigned COL_CYCLES      = 2;
  // Bit position of the plane select inside the 24-bit row address.
  localparam int unsigned PLANE_BIT_POS   = 6;
  localparam int unsigned STAT_FAIL_BIT   = 0;
  localparam int unsigned STAT_READY_BIT  = 6;
  // Strobe phase width in ns and in cycles (a least time, rounded up).
  localparam int unsigned STROBE_NS       = 25;
  localparam int unsigned STROBE_CYC      = (STROBE_NS * CLK_MHZ + 999) / 1000;
  // Wait after a strobe before ready/busy is trusted (least time).
  localparam int unsigned WB_NS           = 100;
  localparam int unsigned WB_CYC          = (WB_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W           = 8;

  typedef enum logic [1:0] {
    NTPSEQ_LAT_CMD  = 2'b00,
    NTPSEQ_LAT_ADDR = 2'b01,
    NTPSEQ_LAT_DIN  = 2'b10,
    NTPSEQ_LAT_DOUT = 2'b11
  } ntpseq_lat_type;

  typedef enum logic [4:0] {
    NTPSEQ_INIT       = 5'h00,
    NTPSEQ_IDLE       = 5'h01,
    NTPSEQ_P_SETUP    = 5'h02,
    NTPSEQ_P_COL      = 5'h03,
    NTPSEQ_P_ROW      = 5'h04,
    NTPSEQ_P_DATA     = 5'h05,
    NTPSEQ_P_CONF     = 5'h06,
    NTPSEQ_E_SETUP    = 5'h07,
    NTPSEQ_E_ROW      = 5'h08,
    NTPSEQ_E_CONF     = 5'h09,
    NTPSEQ_WAIT_BUSY  = 5'h0a,
    NTPSEQ_ST_CMD     = 5'h0b,
    NTPSEQ_ST_READ    = 5'h0c,
    NTPSEQ_RST_CMD    = 5'h0d,
    NTPSEQ_DONE       = 5'h0e
  } ntpseq_state_type;
endpackage : ntpseq_pkg

// >>> core/ntpseq_strobe.sv
// One flash bus cycle: strobe low phase with the latch raised, then strobe high phase.
// Registers kind and data at start, so the caller need not hold them while busy is high.
`timescale 1ns/1ns
module ntpseq_strobe (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic                       start,
  input  wire ntpseq_pkg::ntpseq_lat_type kind,
  input  wire logic [7:0]                 wdata,
  input  wire logic [7:0]                 io_in,
  output logic                            busy,
  output logic                            done,
  output logic                            cle,
  output logic                            ale,
  output logic                            we_n,
  output logic                            re_n,
  output logic [7:0]                      io_out,
  output logic                            io_oe,
  output logic [7:0]                      rdata
);
  import ntpseq_pkg::*;

  logic [1:0]       phase;
  logic [1:0]       next_phase;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  ntpseq_lat_type   cur;
  ntpseq_lat_type   next_cur;
  logic [7:0]       next_rdata;
  logic [7:0]       next_io_out;

  always_comb begin
    next_phase  = phase;
    next_cnt    = cnt;
    next_cur    = cur;
    next_rdata  = rdata;
    next_io_out = io_out;
    done        = 1'b0;
    if (phase == 2'd0) begin
      if (start) begin
        next_phase  = 2'd1;
        next_cur    = kind;
        next_io_out = wdata;
        next_cnt    = CNT_W'(STROBE_CYC - 1);
      end
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end else if (phase == 2'd1) begin
      next_phase = 2'd2;
      next_cnt   = CNT_W'(STROBE_CYC - 1);
      // Read data is taken just before the rising read strobe.
      if (cur == NTPSEQ_LAT_DOUT) begin
        next_rdata = io_in;
      end
    end else begin
      next_phase = 2'd0;
      done       = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase  <= 2'd0;
      cnt    <= '0;
      cur    <= NTPSEQ_LAT_CMD;
      rdata  <= 8'h00;
      io_out <= 8'h00;
    end else begin
      phase  <= next_phase;
      cnt    <= next_cnt;
      cur    <= next_cur;
      rdata  <= next_rdata;
      io_out <= next_io_out;
    end
  end

  assign busy  = (phase != 2'd0);
  assign cle   = busy && (cur == NTPSEQ_LAT_CMD);
  assign ale   = busy && (cur == NTPSEQ_LAT_ADDR);
  assign io_oe = busy && (cur != NTPSEQ_LAT_DOUT);
  assign we_n  = !(phase == 2'd1 && cur != NTPSEQ_LAT_DOUT);
  assign re_n  = !(phase == 2'd1 && cur == NTPSEQ_LAT_DOUT);
endmodule : ntpseq_strobe

// >>> core/ntpseq_host.sv
// Host sequencer for two-plane cache program and two-plane block erase.
// Assumes an 8-bit flash port with pull-up on ready/busy, and a user that
// streams page bytes with valid/ready.
`timescale 1ns/1ns
module ntpseq_host #(
  parameter int unsigned PAGE_BYTES = 2112
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        op_valid,
  input  wire logic        op_erase,
  input  wire logic        op_last,
  input  wire logic [23:0] op_row,
  input  wire logic        abort,
  output logic             op_ready,
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_data,
  output logic             wr_ready,
  output logic             op_done,
  output logic             op_fail,
  output logic             flash_cle,
  output logic             flash_ale,
  output logic             flash_we_n,
  output logic             flash_re_n,
  output logic             flash_wp_n,
  output logic [7:0]       flash_io_out,
  output logic             flash_io_oe,
  input  wire logic [7:0]  flash_io_in,
  input  wire logic        flash_rb_n
);
  import ntpseq_pkg::*;

  logic       rb_meta;
  logic       rb_sync;
  logic [7:0] io_meta;
  logic [7:0] io_sync;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_meta <= 1'b0;
      rb_sync <= 1'b0;
      io_meta <= 8'h00;
      io_sync <= 8'h00;
    end else begin
      rb_meta <= flash_rb_n;
      rb_sync <= rb_meta;
      io_meta <= flash_io_in;
      io_sync <= io_meta;
    end
  end

  ntpseq_state_type state;
  ntpseq_state_type next_state;
  ntpseq_state_type after_wait;
  ntpseq_state_type next_after_wait;
  logic [11:0]      bcnt;
  logic [11:0]      next_bcnt;
  logic [CNT_W-1:0] wcnt;
  logic [CNT_W-1:0] next_wcnt;
  logic             plane;
  logic             next_plane;
  logic             erase;
  logic             next_erase;
  logic             last;
  logic             next_last;
  logic [23:0]      row;
  logic [23:0]      next_row;
  logic             next_op_done;
  logic             next_op_fail;
  logic             st_start;
  ntpseq_lat_type   st_kind;
  logic [7:0]       st_wdata;
  logic             st_busy;
  logic             st_done;
  logic [7:0]       st_rdata;

  ntpseq_strobe u_strobe (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (st_start),
    .kind   (st_kind),
    .wdata  (st_wdata),
    .io_in  (io_sync),
    .busy   (st_busy),
    .done   (st_done),
    .cle    (flash_cle),
    .ale    (flash_ale),
    .we_n   (flash_we_n),
    .re_n   (flash_re_n),
    .io_out (flash_io_out),
    .io_oe  (flash_io_oe),
    .rdata  (st_rdata)
  );

  // Row address with the plane bit forced per plane; one byte is sent per cycle.
  logic [23:0] row_pl;
  assign row_pl = plane ? (row | (24'h000001 << PLANE_BIT_POS))
                        : (row & ~(24'h000001 << PLANE_BIT_POS));

  always_comb begin
    next_state      = state;
    next_after_wait = after_wait;
    next_bcnt       = bcnt;
    next_wcnt       = wcnt;
    next_plane      = plane;
    next_erase      = erase;
    next_last       = last;
    next_row        = row;
    next_op_done    = 1'b0;
    next_op_fail    = op_fail;
    st_start        = 1'b0;
    st_kind         = NTPSEQ_LAT_CMD;
    st_wdata        = 8'h00;
    op_ready        = 1'b0;
    wr_ready        = 1'b0;
    unique case (state)
      // Power-up busy: nothing is sent until ready/busy rises.
      NTPSEQ_INIT: begin
        if (rb_sync) begin
          next_state = NTPSEQ_IDLE;
        end
      end
      NTPSEQ_IDLE: begin
        op_ready = rb_sync;
        if (op_valid && rb_sync) begin
          next_erase = op_erase;
          next_last  = op_last;
          next_row   = op_row;
          next_plane = 1'b0;
          next_bcnt  = '0;
          next_state = op_erase ? NTPSEQ_E_SETUP : NTPSEQ_P_SETUP;
        end
      end
      NTPSEQ_P_SETUP: begin
        st_wdata = plane ? CMD_NEXT_PLANE : CMD_PROG_SETUP;
        st_start = !st_busy;
        if (st_done) begin
          next_state = NTPSEQ_P_COL;
        end
      end
      NTPSEQ_P_COL: begin
        st_kind  = NTPSEQ_LAT_ADDR;
        st_start = !st_busy;
        if (st_done) begin
          next_bcnt = bcnt + 12'h001;
          if (bcnt == 12'(COL_CYCLES - 1)) begin
            next_bcnt  = '0;
            next_state = NTPSEQ_P_ROW;
          end
        end
      end
      NTPSEQ_P_ROW, NTPSEQ_E_ROW: begin
        st_kind  = NTPSEQ_LAT_ADDR;
        st_wdata = row_pl[8*bcnt[1:0] +: 8];
        st_start = !st_busy;
        if (st_done) begin
          next_bcnt = bcnt + 12'h001;
          if (bcnt == 12'(ROW_CYCLES - 1)) begin
            next_bcnt = '0;
            if (erase) begin
              next_plane = 1'b1;
              next_state = plane ? NTPSEQ_E_CONF
                                 : NTPSEQ_E_SETUP;
            end else begin
              next_state = NTPSEQ_P_DATA;
            end
          end
        end
      end
      NTPSEQ_P_DATA: begin
        st_kind  = NTPSEQ_LAT_DIN;
        st_wdata = wr_data;
        wr_ready = !st_busy;
        st_start = !st_busy && wr_valid;
        if (st_done) begin
          next_bcnt = bcnt + 12'h001;
          if (bcnt == 12'(PAGE_BYTES - 1)) begin
            next_state = NTPSEQ_P_CONF;
          end
        end
      end
      NTPSEQ_P_CONF: begin
        // First plane closes with the dummy command; the last page uses
        // the true program, others the cache program command.
        if (!plane) begin
          st_wdata = CMD_DUMMY_PROG;
        end else begin
          st_wdata = last ? CMD_PAGE_PROG : CMD_CACHE_PROG;
        end
        st_start = !st_busy;
        if (st_done) begin
          next_wcnt       = CNT_W'(WB_CYC);
          next_after_wait = plane ? NTPSEQ_ST_CMD : NTPSEQ_P_SETUP;
          next_plane      = 1'b1;
          next_bcnt       = '0;
          next_state      = NTPSEQ_WAIT_BUSY;
        end
      end
      NTPSEQ_E_SETUP: begin
        st_wdata = CMD_ERASE_SETUP;
        st_start = !st_busy;
        if (st_done) begin
          next_state = NTPSEQ_E_ROW;
        end
      end
      NTPSEQ_E_CONF: begin
        st_wdata = CMD_ERASE_CONF;
        st_start = !st_busy;
        if (st_done) begin
          next_wcnt       = CNT_W'(WB_CYC);
          next_after_wait = NTPSEQ_ST_CMD;
          next_state      = NTPSEQ_WAIT_BUSY;
        end
      end
      // Busy covers the dummy, cache and final page times alike; the
      // final page may include the previous cached cycle.
      NTPSEQ_WAIT_BUSY: begin
        if (wcnt != '0) begin
          next_wcnt = wcnt - 1'b1;
        end else if (rb_sync) begin
          next_state = after_wait;
        end
      end
      NTPSEQ_ST_CMD: begin
        st_wdata = CMD_STATUS;
        st_start = !st_busy;
        if (st_done) begin
          next_state = NTPSEQ_ST_READ;
        end
      end
      NTPSEQ_ST_READ: begin
        st_kind  = NTPSEQ_LAT_DOUT;
        st_start = !st_busy;
        if (st_done) begin
          next_state = NTPSEQ_DONE;
        end
      end
      NTPSEQ_DONE: begin
        next_op_fail = st_rdata[STAT_FAIL_BIT]
                    || !st_rdata[STAT_READY_BIT];
        next_op_done = 1'b1;
        next_state   = NTPSEQ_IDLE;
      end
      NTPSEQ_RST_CMD: begin
        st_wdata = CMD_RESET;
        st_start = !st_busy;
        if (st_done) begin
          next_wcnt       = CNT_W'(WB_CYC);
          next_after_wait = NTPSEQ_IDLE;
          next_state      = NTPSEQ_WAIT_BUSY;
        end
      end
      default: begin
        next_state = NTPSEQ_IDLE;
      end
    endcase
    // Abort is taken only between strobes, so no cycle is cut short.
    // A held abort is taken once: never when idle nor during the reset's
    // own busy wait, or the reset command would be reissued without end.
    if (abort && !st_busy && state != NTPSEQ_INIT
        && state != NTPSEQ_RST_CMD && state != NTPSEQ_IDLE
        && !(state == NTPSEQ_WAIT_BUSY && after_wait == NTPSEQ_IDLE)) begin
      next_state = NTPSEQ_RST_CMD;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= NTPSEQ_INIT;
      after_wait <= NTPSEQ_IDLE;
      bcnt       <= '0;
      wcnt       <= '0;
      plane      <= 1'b0;
      erase      <= 1'b0;
      last       <= 1'b0;
      row        <= 24'h000000;
      op_done    <= 1'b0;
      op_fail    <= 1'b0;
    end else begin
      state      <= next_state;
      after_wait <= next_after_wait;
      bcnt       <= next_bcnt;
      wcnt       <= next_wcnt;
      plane      <= next_plane;
      erase      <= next_erase;
      last       <= next_last;
      row        <= next_row;
      op_done    <= next_op_done;
      op_fail    <= next_op_fail;
    end
  end

  // Write protect is held deasserted from reset; the host never raises
  // it, so no busy operation can see it change.
  assign flash_wp_n = 1'b1;

  init_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
    state == NTPSEQ_INIT |-> !flash_we_n == 1'b0 && !flash_cle)
    else $error("Strobe issued during power-up busy.");

  wp_high_a: assert property (@(posedge clk) disable iff (!arst_n)
    flash_wp_n)
    else $error("Write protect asserted.");

  erase_conf_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(state == NTPSEQ_E_CONF) |-> $past(plane))
    else $error("Erase confirm before second block address.");

  wait_ready_a: assert property (@(posedge clk) disable iff (!arst_n)
    state == NTPSEQ_WAIT_BUSY && !rb_sync |=> state == NTPSEQ_WAIT_BUSY
    || state == NTPSEQ_RST_CMD)
    else $error("Left busy wait while device busy.");

  dummy_cmd_a: assert property (@(posedge clk) disable iff (!arst_n)
    state == NTPSEQ_P_CONF && !plane && st_start
    |-> st_wdata == CMD_DUMMY_PROG)
    else $error("First plane not closed with dummy program.");

  next_plane_a: assert property (@(posedge clk) disable iff (!arst_n)
    state == NTPSEQ_P_SETUP && plane && st_start
    |-> st_wdata == CMD_NEXT_PLANE)
    else $error("Second plane setup not next-plane input.");

  plane_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == NTPSEQ_P_ROW || state == NTPSEQ_E_ROW) && bcnt == '0 && st_busy
    |-> flash_io_out[PLANE_BIT_POS] == plane)
    else $error("Plane select bit mismatch.");

  fail_status_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    state == NTPSEQ_DONE && st_rdata[STAT_FAIL_BIT] |=> op_done && op_fail)
    else $error("Status failure not reported.");
endmodule : ntpseq_host

// >>> sim/ntpseq_flash_model.sv
// Behavioural two-plane flash device facing the host sequencer.
// Assumes the bench clock for its busy timing and a pull-up on rb_n.
`timescale 1ns/1ns
module ntpseq_flash_model #(
  parameter int INIT_CYC = 40,
  parameter int DBSY_CYC = 20,
  parameter int PROG_CYC = 150,
  parameter int ERS_CYC  = 300
) (
  input  wire logic       clk,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_in,
  input  wire logic       fail_next,
  output logic [7:0]      io_out,
  output logic            rb_n
);
  logic [9:0] log_q[$];
  int         busy = INIT_CYC;
  int         bg = 0;
  logic       we_d = 1'b1;
  logic       fail = 1'b0;
  logic [7:0] last = 8'h00;
  // Released open-drain line: the pull-up wins whenever busy has run out.
  assign rb_n = (busy == 0);
  // A released data bus shows the inverse of the last value, not a hold.
  always_comb begin
    if (!re_n) io_out = {wp_n, rb_n, rb_n, 4'h0, fail};
    else io_out = ~last;
  end
  always @(posedge clk) begin
    we_d <= we_n;
    if (!re_n) last <= io_out;
    if (busy > 0) busy <= busy - 1;
    if (bg > 0) bg <= bg - 1;
    if (we_n && !we_d) begin
      log_q.push_back({cle ? 2'd0 : (ale ? 2'd1 : 2'd2), io_in});
      if (cle) begin
        case (io_in)
          8'h11: busy <= DBSY_CYC;
          8'h15: if (wp_n) begin
            busy <= bg + DBSY_CYC;
            bg <= PROG_CYC;
            fail <= fail_next;
          end
          8'h10: if (wp_n) begin
            busy <= bg + PROG_CYC;
            bg <= 0;
            fail <= fail_next;
          end
          8'hd0: if (wp_n) begin
            busy <= ERS_CYC;
            fail <= fail_next;
          end
          8'hff: begin
            busy <= 5;
            bg <= 0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : ntpseq_flash_model

// >>> sim/ntpseq_host_test.sv
// Self-checking bench for the two-plane host sequencer.
// Assumes the behavioural device in ntpseq_flash_model.sv.
`timescale 1ns/1ns
module ntpseq_host_test;
  import ntpseq_pkg::*;
  localparam int PB = 4;
  logic        clk;
  logic        arst_n;
  logic        op_valid;
  logic        op_erase;
  logic        op_last;
  logic [23:0] op_row;
  logic        abort;
  logic        op_ready;
  logic        wr_valid;
  logic [7:0]  wr_data;
  logic        wr_ready;
  logic        op_done;
  logic        op_fail;
  logic        cle;
  logic        ale;
  logic        we_n;
  logic        re_n;
  logic        wp_n;
  logic [7:0]  io_out;
  logic        io_oe;
  logic [7:0]  io_in;
  logic        rb_n;
  logic        fail_next;
  logic [9:0]  exp_q[$];
  logic [7:0]  pg[2*PB];
  int          mismatches;
  int          checks;
  int          seed;
  wire  [7:0]  bus = io_oe ? io_out : io_in;

  ntpseq_host #(.PAGE_BYTES(PB)) u_dut (.clk(clk), .arst_n(arst_n),
    .op_valid(op_valid), .op_erase(op_erase), .op_last(op_last),
    .op_row(op_row), .abort(abort), .op_ready(op_ready),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .op_done(op_done), .op_fail(op_fail), .flash_cle(cle),
    .flash_ale(ale), .flash_we_n(we_n), .flash_re_n(re_n),
    .flash_wp_n(wp_n), .flash_io_out(io_out), .flash_io_oe(io_oe),
    .flash_io_in(io_in), .flash_rb_n(rb_n));
  ntpseq_flash_model u_dev (.clk(clk), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .io_in(bus), .fail_next(fail_next),
    .io_out(io_in), .rb_n(rb_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cmp_bit(string nm, logic e, logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_ent(string nm, logic [9:0] e, logic [9:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_ent

  // Polls at the falling edge so the design's edge updates have landed.
  task automatic wait_for(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== v && n < 3000);
    cmp_bit(nm, v, s);
  endtask : wait_for

  function automatic void push(ntpseq_lat_type k, logic [7:0] b);
    exp_q.push_back({k, b});
  endfunction : push

  function automatic void push_row(logic [23:0] r, logic p);
    r[PLANE_BIT_POS] = p;
    push(NTPSEQ_LAT_ADDR, r[7:0]);
    push(NTPSEQ_LAT_ADDR, r[15:8]);
    push(NTPSEQ_LAT_ADDR, r[23:16]);
  endfunction : push_row

  function automatic void expect_op(logic e, logic l, logic [23:0] r);
    exp_q.delete();
    for (int p = 0; p < 2; p++) begin
      if (e) begin
        push(NTPSEQ_LAT_CMD, CMD_ERASE_SETUP);
        push_row(r, p[0]);
      end else begin
        push(NTPSEQ_LAT_CMD, p[0] ? CMD_NEXT_PLANE : CMD_PROG_SETUP);
        push(NTPSEQ_LAT_ADDR, 8'h00);
        push(NTPSEQ_LAT_ADDR, 8'h00);
        push_row(r, p[0]);
        for (int i = 0; i < PB; i++) push(NTPSEQ_LAT_DIN, pg[p*PB+i]);
        if (p == 0) push(NTPSEQ_LAT_CMD, CMD_DUMMY_PROG);
        else push(NTPSEQ_LAT_CMD, l ? CMD_PAGE_PROG : CMD_CACHE_PROG);
      end
    end
    if (e) push(NTPSEQ_LAT_CMD, CMD_ERASE_CONF);
    push(NTPSEQ_LAT_CMD, CMD_STATUS);
  endfunction : expect_op

  // Random one-cycle gaps drop valid while the strobe is still busy, so they never stall the stream.
  task automatic feed();
    for (int i = 0; i < 2*PB; i++) begin
      wr_valid <= 1'b1;
      wr_data <= pg[i];
      wait_for(wr_ready, 1'b1, "wr_ready");
      @(posedge clk);
      if (($random(seed) & 3) == 0) begin
        wr_valid <= 1'b0;
        @(posedge clk);
      end
    end
    wr_valid <= 1'b0;
  endtask : feed

  task automatic start_op(logic e, logic l, logic [23:0] r, logic f);
    for (int i = 0; i < 2*PB; i++) pg[i] = 8'($random(seed));
    expect_op(e, l, r);
    u_dev.log_q.delete();
    @(posedge clk);
    op_valid <= 1'b1;
    op_erase <= e;
    op_last <= l;
    op_row <= r;
    fail_next <= f;
    wait_for(op_ready, 1'b1, "op_ready");
    @(posedge clk);
    op_valid <= 1'b0;
    if (!e) feed();
  endtask : start_op

  task automatic run_op(logic e, logic l, logic [23:0] r, logic f);
    start_op(e, l, r, f);
    wait_for(op_done, 1'b1, "op_done");
    @(negedge clk);
    cmp_bit("op_fail", f, op_fail);
    cmp_bit("wp_n", 1'b1, wp_n);
    cmp_ent("log size", 10'(exp_q.size()), 10'(u_dev.log_q.size()));
    foreach (exp_q[i])
      cmp_ent("log entry", exp_q[i],
              u_dev.log_q[i]);
  endtask : run_op

  initial begin
    seed = 32'h1ce9e1bc;
    mismatches = 0;
    checks = 0;
    arst_n = 1'b0;
    op_valid = 1'b0;
    op_erase = 1'b0;
    op_last = 1'b0;
    op_row = 24'h000000;
    abort = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    fail_next = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(negedge clk);
    cmp_bit("op_ready", 1'b0, op_ready);
    wait_for(op_ready, 1'b1, "op_ready");
    cmp_ent("log size", 10'h000, 10'(u_dev.log_q.size()));
    run_op(1'b0, 1'b0, 24'hffffff, 1'b0);
    run_op(1'b0, 1'b1, 24'h000000, 1'b1);
    run_op(1'b1, 1'b0, 24'h000040, 1'b1);
    start_op(1'b1, 1'b0, 24'h123456, 1'b0);
    wait_for(rb_n, 1'b0, "rb_n");
    repeat (20) @(posedge clk);
    abort <= 1'b1;
    wait_for(op_ready, 1'b1, "op_ready");
    @(posedge clk);
    abort <= 1'b0;
    cmp_ent("last cmd", {NTPSEQ_LAT_CMD, CMD_RESET}, u_dev.log_q[$]);
    cmp_bit("rb_n", 1'b1, rb_n);
    for (int k = 0; k < 6; k++) begin
      run_op(1'($random(seed)), 1'($random(seed)), 24'($random(seed)),
             1'($random(seed)));
    end
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : ntpseq_host_test
